// ==== bench/rfc_conv_ctrl_props.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "rfc_map.svh"
module rfc_conv_ctrl_props (
  // clock and reset
  input wire logic                            clk,
  input wire logic                            srst,
  input wire logic                            ce,
  // register bus
  input wire logic [17:0]                     avs_address,
  input wire logic                            avs_read,
  input wire logic                            avs_write,
  input wire logic [31:0]                     avs_writedata,
  input wire logic [3:0]                      avs_byteenable,
  input wire logic [31:0]                     avs_readdata,
  input wire logic                            avs_waitrequest,
  // oscillator controls and interrupt
  input wire rfc_pkg::rfc_chan_ctl_type [1:0] chanCtl,
  input wire logic                            irqRequest
);
  logic [15:0] idx;
  logic [15:0] rsvMask;
  logic        wrDone;
  logic [1:0]  chOn;
  logic [6:0]  shadow_r;
  logic [6:0]  shadow_nxt;
  // access decode and running channels
  assign idx = avs_address[17:2];
  assign wrDone = avs_write & ~avs_waitrequest & ce & avs_byteenable[0];
  assign chOn[0] = chanCtl[0].refOn | chanCtl[0].sensAOn | chanCtl[0].sensBOn;
  assign chOn[1] = chanCtl[1].refOn | chanCtl[1].sensAOn | chanCtl[1].sensBOn;
  // reserved bits of each register, all bits where unmapped
  always_comb begin
    case (idx)
      `RFC_IDX_CTL: rsvMask = 16'hff0c;
      `RFC_IDX_TRG: rsvMask = 16'hfff8;
      `RFC_IDX_MCL, `RFC_IDX_TCL: rsvMask = 16'h0000;
      `RFC_IDX_MCH, `RFC_IDX_TCH: rsvMask = 16'hff00;
      `RFC_IDX_IMSK, `RFC_IDX_IFLG: rsvMask = 16'hffe0;
      `RFC_IDX_CKCTL: rsvMask = 16'hfff0;
      default: rsvMask = 16'hffff;
    endcase
  end
  // shadow of mask [4:0], converter enable [5] and clock gate [6]
  always_comb begin
    shadow_nxt = shadow_r;
    if (wrDone && idx == `RFC_IDX_IMSK) shadow_nxt[4:0] = avs_writedata[4:0];
    if (wrDone && idx == `RFC_IDX_CTL) shadow_nxt[5] = avs_writedata[0];
    if (wrDone && idx == `RFC_IDX_CKCTL) shadow_nxt[6] = avs_writedata[0];
  end
  // shadow register
  always_ff @(posedge clk) begin
    if (srst) shadow_r <= 7'h00;
    else shadow_r <= shadow_nxt;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence busReq;
    (avs_read || avs_write) && avs_waitrequest && ce;
  endsequence
  sequence trgStart;
    wrDone && idx == `RFC_IDX_TRG && avs_writedata[1:0] != 2'h0 && shadow_r[5] && shadow_r[6];
  endsequence
  sequence trgStop;
    wrDone && idx == `RFC_IDX_TRG && avs_writedata[2:0] == 3'h0 && shadow_r[6];
  endsequence
  sequence clrAll;
    wrDone && idx == `RFC_IDX_IFLG && avs_writedata[4:0] == 5'h1f;
  endsequence
  one_wait_a: assert property (busReq |=> !avs_waitrequest) else $error("bus answer late");
  idle_nowait_a: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("wait while idle");
  rsv_zero_a: assert property (avs_read && !avs_waitrequest |->
    (avs_readdata & {16'hffff, rsvMask}) == 32'h0) else $error("reserved bits set");
  one_chan_a: assert property (!(chOn[0] && chOn[1])) else $error("two channels run");
  senb_mode_a: assert property (
    !(chanCtl[0].sensBOn && chanCtl[0].sensorMode != rfc_pkg::RFC_DC_RES) &&
    !(chanCtl[1].sensBOn && chanCtl[1].sensorMode != rfc_pkg::RFC_DC_RES))
    else $error("sensor b outside dc mode");
  mask_irq_a: assert property (shadow_r[4:0] == 5'h0 |-> !irqRequest)
    else $error("irq while masked");
  dis_hold_a: assert property (!shadow_r[5] && chOn == 2'h0 |=> chOn == 2'h0)
    else $error("start while disabled");
  start_run_a: assert property (trgStart |-> ##[1:60] chOn != 2'h0)
    else $error("no start");
  stop_run_a: assert property (trgStop |-> ##[1:60] chOn == 2'h0)
    else $error("no stop");
  clr_flag_a: assert property ((chOn == 2'h0) [*3] ##0 clrAll |=> !irqRequest)
    else $error("flags not cleared");
endmodule : rfc_conv_ctrl_props
bind rfc_conv_ctrl rfc_conv_ctrl_props u_props (
  .clk, .srst, .ce, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_readdata, .avs_waitrequest, .chanCtl, .irqRequest
);
`default_nettype wire

// ==== bench/rfc_osc_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module rfc_osc_model (
  // clock
  input  wire logic                            clk,
  // controls from the converter
  input  wire rfc_pkg::rfc_chan_ctl_type [1:0] chanCtl,
  // oscillator outputs
  output logic [1:0]                           crOsc,
  output logic [1:0]                           extPin
);
  logic [1:0] on;
  // a channel runs while any of its oscillations is on
  assign on[0] = chanCtl[0].refOn | chanCtl[0].sensAOn | chanCtl[0].sensBOn;
  assign on[1] = chanCtl[1].refOn | chanCtl[1].sensAOn | chanCtl[1].sensBOn;
  // cr output stands low when idle; pin is pulled down outside event mode
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      crOsc[i] <= on[i] & ~chanCtl[i].eventMode & ~crOsc[i];
      extPin[i] <= chanCtl[i].eventMode & ~extPin[i];
    end
  end
endmodule : rfc_osc_model
`default_nettype wire

// ==== bench/tb_rfc_conv_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "rfc_map.svh"
module tb_rfc_conv_ctrl;
  localparam logic W = 1'b1;
  localparam logic R = 1'b0;
  logic                            clk, srst, avsRead, avsWrite, lowSpeedOsc, irqRequest;
  logic                            avsWaitrequest;
  logic [17:0]                     avsAddress;
  logic [31:0]                     avsWritedata, avsReaddata;
  logic [3:0]                      avsByteenable;
  logic [1:0]                      crOsc, extPin;
  rfc_pkg::rfc_chan_ctl_type [1:0] chanCtl;
  logic [15:0]                     rdv, seed, ix;
  logic [15:0]                     ckTab [5] = '{16'h0001, 16'h0005, 16'h0009, 16'h000d, 16'h0003};
  int                              nFail, samplesChecked, cyc;
  // ----------------------------------------------------------------------
  // design, far side and clocks
  // ----------------------------------------------------------------------
  rfc_conv_ctrl uut (.clk(clk), .srst(srst), .ce(1'b1), .avs_address(avsAddress),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
    .avs_byteenable(avsByteenable), .avs_readdata(avsReaddata),
    .avs_waitrequest(avsWaitrequest), .lowSpeedOscillator(lowSpeedOsc),
    .crOscillation(crOsc), .oscillatorInputPin(extPin), .chanCtl(chanCtl),
    .irqRequest(irqRequest));
  rfc_osc_model u_osc (.clk(clk), .chanCtl(chanCtl), .crOsc(crOsc), .extPin(extPin));
  // 8 ns clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // slow oscillator rises every 16 cycles; cycle counter
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc % 8 == 7) lowSpeedOsc <= ~lowSpeedOsc;
  end
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [15:0] rwMask(input logic [15:0] i);
    case (i)
      `RFC_IDX_MCL, `RFC_IDX_TCL: return 16'hffff;
      `RFC_IDX_MCH, `RFC_IDX_TCH: return 16'h00ff;
      `RFC_IDX_IMSK: return 16'h001f;
      default: return 16'h0000;
    endcase
  endfunction : rwMask
  function automatic int period(input logic [15:0] ck);
    return ck[1] ? 16 : (1 << ck[3:2]);
  endfunction : period
  task automatic endSim();
    $display("checks %0d failures %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : endSim
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    samplesChecked++;
    if (g !== e) begin
      nFail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp
  task automatic cmpIn(input string nm, input logic [15:0] lo, hi, g);
    samplesChecked++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      nFail++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : cmpIn
  task automatic cmpIrq(input logic e);
    @(negedge clk);
    cmp("irq", {15'h0, e}, {15'h0, irqRequest});
  endtask : cmpIrq
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [15:0] i, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avsAddress <= {i, 2'h0};
    avsWritedata <= {16'h0, d};
    avsWrite <= w;
    avsRead <= ~w;
    // request stands until the rising edge that sees waitrequest low
    do begin
      @(posedge clk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 50);
    if (avsWaitrequest !== 1'b0) nFail++;
    rdv = avsReaddata[15:0];
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask : bus
  task automatic load(input logic [15:0] lo, input logic [23:0] v);
    bus(W, lo, v[15:0]);
    bus(W, lo + 16'h2, {8'h0, v[23:16]});
  endtask : load
  task automatic poll(input logic [15:0] m);
    rdv = m;
    for (int i = 0; i < 300 && (rdv & m) != 16'h0; i++) bus(R, `RFC_IDX_TRG, 16'h0);
    if ((rdv & m) != 16'h0) nFail++;
  endtask : poll
  // one sensor run; its length shows the tick rate
  task automatic sense(input logic [15:0] ck, input logic [15:0] t);
    int t0;
    int p;
    p = period(ck);
    bus(W, `RFC_IDX_CKCTL, ck);
    bus(W, `RFC_IDX_IFLG, 16'h001f);
    bus(W, `RFC_IDX_IMSK, t);
    load(`RFC_IDX_MCL, 24'h0);
    load(`RFC_IDX_TCL, 24'h000020);
    t0 = cyc;
    bus(W, `RFC_IDX_TRG, t);
    poll(t);
    cmpIn("run_cycles", 16'(31 * p), 16'(33 * p + 24), 16'(cyc - t0));
    bus(R, `RFC_IDX_TCL, 16'h0);
    cmp("tb_zero", 16'h0, rdv);
    bus(R, `RFC_IDX_IFLG, 16'h0);
    cmp("done_flag", t, rdv);
    cmpIrq(1'b1);
    bus(W, `RFC_IDX_IFLG, 16'h0);
    bus(R, `RFC_IDX_IFLG, 16'h0);
    cmp("flag_kept", t, rdv);
    bus(W, `RFC_IDX_IFLG, t);
    cmpIrq(1'b0);
  endtask : sense
  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    #480000;
    nFail++;
    endSim();
  end
  initial begin
    {srst, avsRead, avsWrite, lowSpeedOsc, avsAddress, avsWritedata} = '0;
    srst = 1'b1;
    avsByteenable = 4'h3;
    seed = 16'h004b;
    cyc = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      bus(R, 16'h53a0 + 16'(2 * i), 16'h0);
      cmp("reset", (i == 8) ? 16'h0002 : 16'h0, rdv);
    end
    bus(W, `RFC_IDX_TRG, 16'h0001);
    bus(R, `RFC_IDX_TRG, 16'h0);
    cmp("trg_disabled", 16'h0, rdv);
    for (int k = 0; k < 20; k++) begin
      seed = lfsr(seed);
      ix = 16'h53a4 + 16'(2 * (k % 5));
      bus(W, ix, seed);
      bus(R, ix, 16'h0);
      cmp("rw", seed & rwMask(ix), rdv);
    end
    bus(W, 16'h53b2, 16'hffff);
    bus(R, 16'h53b2, 16'h0);
    cmp("unmapped", 16'h0, rdv);
    bus(W, `RFC_IDX_IMSK, 16'h0);
    avsByteenable <= 4'h2;
    bus(W, `RFC_IDX_IMSK, 16'h001f);
    avsByteenable <= 4'h3;
    bus(R, `RFC_IDX_IMSK, 16'h0);
    cmp("be_low_off", 16'h0, rdv);
    for (int m = 0; m < 3; m++) begin
      bus(W, `RFC_IDX_CTL, 16'(m << 4) | 16'h0003);
      bus(R, `RFC_IDX_CTL, 16'h0);
      cmp("ctl", 16'(m << 4) | 16'h0003, rdv);
      cmp("mode", 16'(m), {14'h0, chanCtl[1].sensorMode});
      bus(W, `RFC_IDX_CTL, 16'(m << 4) | 16'h0001);
      bus(W, `RFC_IDX_TRG, 16'h0004);
      bus(R, `RFC_IDX_TRG, 16'h0);
      cmp("senb_block", (m == 0) ? 16'h0004 : 16'h0, rdv);
      bus(W, `RFC_IDX_TRG, 16'h0);
    end
    bus(W, `RFC_IDX_CTL, 16'h0001);
    cmp("mode_ch1", 16'h2, {14'h0, chanCtl[1].sensorMode});
    foreach (ckTab[j]) sense(ckTab[j], (j == 4) ? 16'h0004 : 16'h0002);
    bus(W, `RFC_IDX_IFLG, 16'h001f);
    bus(W, `RFC_IDX_IMSK, 16'h0001);
    load(`RFC_IDX_MCL, 24'hfffff0);
    load(`RFC_IDX_TCL, 24'h0);
    bus(W, `RFC_IDX_TRG, 16'h0001);
    poll(16'h0001);
    bus(R, `RFC_IDX_IFLG, 16'h0);
    cmp("ref_done", 16'h0001, rdv);
    cmpIrq(1'b1);
    bus(W, `RFC_IDX_IFLG, 16'h001f);
    bus(W, `RFC_IDX_CTL, 16'h0081);
    load(`RFC_IDX_TCL, 24'h000004);
    bus(W, `RFC_IDX_TRG, 16'h0002);
    repeat (200) @(posedge clk);
    bus(R, `RFC_IDX_TRG, 16'h0);
    cmp("continuous", 16'h0002, rdv);
    bus(W, `RFC_IDX_TRG, 16'h0);
    repeat (60) @(posedge clk);
    bus(R, `RFC_IDX_IFLG, 16'h0);
    cmp("cont_flags", 16'h0, rdv);
    bus(W, `RFC_IDX_CTL, 16'h0041);
    load(`RFC_IDX_MCL, 24'h0);
    bus(W, `RFC_IDX_TRG, 16'h0001);
    repeat (100) @(posedge clk);
    bus(W, `RFC_IDX_TRG, 16'h0);
    repeat (60) @(posedge clk);
    bus(R, `RFC_IDX_MCL, 16'h0);
    cmpIn("events", 16'd20, 16'd80, rdv);
    bus(W, `RFC_IDX_CTL, 16'h0001);
    bus(W, `RFC_IDX_CKCTL, 16'h0002);
    load(`RFC_IDX_TCL, 24'h000004);
    bus(W, `RFC_IDX_TRG, 16'h0002);
    repeat (100) @(posedge clk);
    bus(R, `RFC_IDX_TCL, 16'h0);
    cmp("gated", 16'h0004, rdv);
    bus(W, `RFC_IDX_CKCTL, 16'h0003);
    bus(W, `RFC_IDX_TRG, 16'h0);
    repeat (60) @(posedge clk);
    bus(R, `RFC_IDX_TRG, 16'h0);
    cmp("stopped", 16'h0, rdv);
    cmp("run_off", 16'h0, 16'({chanCtl[0].refOn, chanCtl[0].sensAOn}));
    endSim();
  end
endmodule : tb_rfc_conv_ctrl
`default_nettype wire

// ==== pkg/rfc_map.svh ====
`ifndef RFC_MAP_SVH
`define RFC_MAP_SVH
// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define RFC_IDX_CTL      16'h53a0
`define RFC_IDX_TRG      16'h53a2
`define RFC_IDX_MCL      16'h53a4
`define RFC_IDX_MCH      16'h53a6
`define RFC_IDX_TCL      16'h53a8
`define RFC_IDX_TCH      16'h53aa
`define RFC_IDX_IMSK     16'h53ac
`define RFC_IDX_IFLG     16'h53ae
`define RFC_IDX_CKCTL    16'h53b0
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CONVERTER_CONTROL_CONT     7
`define CONVERTER_CONTROL_EVT      6
`define CONVERTER_CONTROL_MODE_LO  4
`define CONVERTER_CONTROL_CONVERSION_CHANNEL_SEL    1
`define CONVERTER_CONTROL_EN       0
`define OSCILLATION_TRIGGER_SENB     2
`define OSCILLATION_TRIGGER_SENA     1
`define OSCILLATION_TRIGGER_REF      0
`define RFC_FLG_TCOV     4
`define RFC_FLG_MCOV     3
`define RFC_FLG_SENB     2
`define RFC_FLG_SENA     1
`define RFC_FLG_REF      0
`define RFC_CK_DIV_LO    2
`define RFC_CK_SRC       1
`define RFC_CK_GATE      0
// ----------------------------------------------------------------------
// reset values and counter limits
// ----------------------------------------------------------------------
`define RFC_CKCTL_RST    4'h2
`define RFC_CNT_MAX      24'hffffff
`define RFC_CNT_ONE      24'h000001
`endif

// ==== pkg/rfc_pkg.sv ====
package rfc_pkg;
  // sensor oscillation modes
  typedef enum logic [1:0] {
    RFC_DC_RES = 2'h0,
    RFC_AC_RES = 2'h1,
    RFC_DC_CAP = 2'h2,
    RFC_MODE_RSVD = 2'h3
  } rfc_mode_type;

  // oscillation sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_REF,
    ST_SENA,
    ST_SENB
  } rfc_state_type;

  // per-channel controls toward the oscillator front end
  typedef struct packed {
    logic         refOn;
    logic         sensAOn;
    logic         sensBOn;
    rfc_mode_type sensorMode;
    logic         continuous;
    logic         eventMode;
  } rfc_chan_ctl_type;
endpackage : rfc_pkg

// ==== verilog/rfc_conv_ctrl.sv ====
// Behaviour
// - source select: 1 slow oscillator, 0 fast
// - clock gate resets off; 1 feeds clock
// - continuous bit disables automatic stops
// - event mode counts external pin clock
// - mode field: DC res, AC res, DC cap
// - channel select routes mode bits, triggers
// - converter disabled ignores trigger writes
// - triggers start on 1, stop on 0
// - sensor B blocked in modes 1, 2
// - measurement counter as low, high words
// - time base counter as low, high words
// - five interrupt enables, reset disabled
// - sensor stops at time base zero, overflow
// - flags set on cause, write-one clears
// - one shared masked interrupt line
// - fast clock divided by 1,2,4,8
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
`include "rfc_map.svh"
module rfc_conv_ctrl (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         srst,
  input  wire logic                         ce,
  // avalon-mm slave
  input  wire logic [17:0]                  avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [31:0]                  avs_writedata,
  input  wire logic [3:0]                   avs_byteenable,
  output logic      [31:0]                  avs_readdata,
  output logic                              avs_waitrequest,
  // clocks and oscillator inputs
  input  wire logic                         lowSpeedOscillator,
  input  wire logic [1:0]                   crOscillation,
  input  wire logic [1:0]                   oscillatorInputPin,
  // oscillator controls and interrupt
  output rfc_pkg::rfc_chan_ctl_type [1:0]   chanCtl,
  output logic                              irqRequest
);
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  logic                  done_r, done_nxt;
  logic [31:0]           rdata_r, rdata_nxt;
  logic                  convEn_r, convEn_nxt;
  logic                  chanSel_r, chanSel_nxt;
  logic [3:0]            ctlHi_r [2];
  logic [3:0]            ctlHi_nxt [2];
  logic [3:0]            ckCtl_r, ckCtl_nxt;
  logic [2:0]            trg_r, trg_nxt;
  logic [23:0]           mc_r, mc_nxt;
  logic [23:0]           tc_r, tc_nxt;
  logic [4:0]            mask_r, mask_nxt;
  logic [4:0]            flag_r, flag_nxt;
  logic                  pinPrev_r, pinPrev_nxt;
  rfc_pkg::rfc_state_type state_r, state_nxt;

  logic                  tick;
  logic [15:0]           regIdx;
  logic [15:0]           wmask;
  logic [15:0]           wd;
  logic                  wrHit;
  logic [3:0]            curHi;
  logic                  countIn;
  logic                  oscEdge;
  logic                  mcWrap;
  logic                  tcWrap;
  logic                  tcZero;
  logic [4:0]            ev;
  logic                  stopNow;

  // -----------------------------------------------------------------
  // time base clock
  // -----------------------------------------------------------------
  rfc_tick_gen u_tick (
    .clk                 (clk),
    .srst                (srst),
    .ce                  (ce),
    .countClockGate      (ckCtl_r[`RFC_CK_GATE]),
    .countClockSourceSel (ckCtl_r[`RFC_CK_SRC]),
    .fastClockDividerSel (ckCtl_r[`RFC_CK_DIV_LO +: 2]),
    .lowSpeedOscillator  (lowSpeedOscillator),
    .timeBaseTick        (tick)
  );

  // bus decode and handshake, one wait cycle per access
  assign regIdx          = avs_address[17:2];
  assign wmask           = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wd              = avs_writedata[15:0] & wmask;
  assign wrHit           = avs_write & done_r;
  assign avs_waitrequest = (avs_read | avs_write) & ~done_r;
  assign avs_readdata    = rdata_r;

  // selected channel view
  assign curHi   = ctlHi_r[chanSel_r];
  assign countIn = curHi[`CONVERTER_CONTROL_EVT - 4] ? oscillatorInputPin[chanSel_r]
                                           : crOscillation[chanSel_r];
  assign oscEdge = countIn & ~pinPrev_r & (state_r != rfc_pkg::ST_IDLE);
  assign irqRequest = |(flag_r & mask_r);

  // -----------------------------------------------------------------
  // per-channel outputs
  // -----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      always_comb begin
        chanCtl[ch].refOn      = (chanSel_r == 1'(ch)) & (state_r == rfc_pkg::ST_REF);
        chanCtl[ch].sensAOn    = (chanSel_r == 1'(ch)) & (state_r == rfc_pkg::ST_SENA);
        chanCtl[ch].sensBOn    = (chanSel_r == 1'(ch)) & (state_r == rfc_pkg::ST_SENB);
        chanCtl[ch].sensorMode = rfc_pkg::rfc_mode_type'(ctlHi_r[ch][1:0]);
        chanCtl[ch].continuous = ctlHi_r[ch][`CONVERTER_CONTROL_CONT - 4];
        chanCtl[ch].eventMode  = ctlHi_r[ch][`CONVERTER_CONTROL_EVT - 4];
      end
    end
  endgenerate

  // -----------------------------------------------------------------
  // sequencer, counters and flags
  // -----------------------------------------------------------------
  always_comb begin
    state_nxt   = state_r;
    trg_nxt     = trg_r;
    mc_nxt      = mc_r;
    tc_nxt      = tc_r;
    ev          = 5'h00;
    stopNow     = 1'b0;
    pinPrev_nxt = countIn;
    mcWrap      = oscEdge & (mc_r == `RFC_CNT_MAX);
    tcWrap      = 1'b0;
    tcZero      = 1'b0;
    // measurement counter counts oscillation edges up
    if (oscEdge) begin
      mc_nxt = 24'(mc_r + `RFC_CNT_ONE);
    end
    // time base counts up for reference, down for sensors
    if (tick && state_r == rfc_pkg::ST_REF) begin
      tcWrap = (tc_r == `RFC_CNT_MAX);
      tc_nxt = 24'(tc_r + `RFC_CNT_ONE);
    end else if (tick && state_r != rfc_pkg::ST_IDLE) begin
      tcZero = (tc_r <= `RFC_CNT_ONE);
      tc_nxt = tcZero ? 24'h000000 : 24'(tc_r - `RFC_CNT_ONE);
    end
    // automatic stop conditions, skipped in continuous mode
    if (!curHi[`CONVERTER_CONTROL_CONT - 4]) begin
      case (state_r)
        rfc_pkg::ST_REF: begin
          ev[`RFC_FLG_REF]  = mcWrap;
          ev[`RFC_FLG_TCOV] = tcWrap & ~mcWrap;
        end
        rfc_pkg::ST_SENA: begin
          ev[`RFC_FLG_SENA] = tcZero;
          ev[`RFC_FLG_MCOV] = mcWrap & ~tcZero;
        end
        rfc_pkg::ST_SENB: begin
          ev[`RFC_FLG_SENB] = tcZero;
          ev[`RFC_FLG_MCOV] = mcWrap & ~tcZero;
        end
        default: begin
          ev = 5'h00;
        end
      endcase
      stopNow = |ev;
    end
    // start and stop follow the trigger bits on count clock ticks
    case (state_r)
      rfc_pkg::ST_IDLE: begin
        if (tick && trg_r[`OSCILLATION_TRIGGER_REF]) begin
          state_nxt = rfc_pkg::ST_REF;
        end else if (tick && trg_r[`OSCILLATION_TRIGGER_SENA]) begin
          state_nxt = rfc_pkg::ST_SENA;
        end else if (tick && trg_r[`OSCILLATION_TRIGGER_SENB]) begin
          state_nxt = rfc_pkg::ST_SENB;
        end
      end
      rfc_pkg::ST_REF: begin
        if (stopNow || (tick && !trg_r[`OSCILLATION_TRIGGER_REF])) begin
          state_nxt = rfc_pkg::ST_IDLE;
        end
      end
      rfc_pkg::ST_SENA: begin
        if (stopNow || (tick && !trg_r[`OSCILLATION_TRIGGER_SENA])) begin
          state_nxt = rfc_pkg::ST_IDLE;
        end
      end
      rfc_pkg::ST_SENB: begin
        if (stopNow || (tick && !trg_r[`OSCILLATION_TRIGGER_SENB])) begin
          state_nxt = rfc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = rfc_pkg::ST_IDLE;
      end
    endcase
    if (stopNow) begin
      trg_nxt = 3'h0;
    end
    // software writes to triggers and counters win over counting
    if (wrHit && regIdx == `RFC_IDX_TRG && avs_byteenable[0] && convEn_r) begin
      trg_nxt = wd[2:0];
      if (curHi[1:0] == rfc_pkg::RFC_AC_RES || curHi[1:0] == rfc_pkg::RFC_DC_CAP) begin
        trg_nxt[`OSCILLATION_TRIGGER_SENB] = 1'b0;
      end
    end
    if (wrHit && regIdx == `RFC_IDX_MCL) begin
      mc_nxt[15:0] = (mc_r[15:0] & ~wmask) | wd;
    end
    if (wrHit && regIdx == `RFC_IDX_MCH) begin
      mc_nxt[23:16] = (mc_r[23:16] & ~wmask[7:0]) | wd[7:0];
    end
    if (wrHit && regIdx == `RFC_IDX_TCL) begin
      tc_nxt[15:0] = (tc_r[15:0] & ~wmask) | wd;
    end
    if (wrHit && regIdx == `RFC_IDX_TCH) begin
      tc_nxt[23:16] = (tc_r[23:16] & ~wmask[7:0]) | wd[7:0];
    end
    // write-one clears, a new event in the same cycle wins
    flag_nxt = flag_r;
    if (wrHit && regIdx == `RFC_IDX_IFLG) begin
      flag_nxt = flag_r & ~wd[4:0];
    end
    flag_nxt = flag_nxt | ev;
  end

  // -----------------------------------------------------------------
  // configuration registers
  // -----------------------------------------------------------------
  always_comb begin
    convEn_nxt  = convEn_r;
    chanSel_nxt = chanSel_r;
    ctlHi_nxt   = ctlHi_r;
    ckCtl_nxt   = ckCtl_r;
    mask_nxt    = mask_r;
    if (wrHit && regIdx == `RFC_IDX_CTL && avs_byteenable[0]) begin
      convEn_nxt = avs_writedata[`CONVERTER_CONTROL_EN];
      chanSel_nxt = avs_writedata[`CONVERTER_CONTROL_CONVERSION_CHANNEL_SEL];
      ctlHi_nxt[avs_writedata[`CONVERTER_CONTROL_CONVERSION_CHANNEL_SEL]] = avs_writedata[7:4];
    end
    if (wrHit && regIdx == `RFC_IDX_CKCTL && avs_byteenable[0]) begin
      ckCtl_nxt = avs_writedata[3:0];
    end
    if (wrHit && regIdx == `RFC_IDX_IMSK && avs_byteenable[0]) begin
      mask_nxt = avs_writedata[4:0];
    end
  end

  // -----------------------------------------------------------------
  // bus handshake and read mux
  // -----------------------------------------------------------------
  always_comb begin
    done_nxt  = (avs_read | avs_write) & ~done_r;
    rdata_nxt = rdata_r;
    if (avs_read && !done_r) begin
      case (regIdx)
        `RFC_IDX_CTL:   rdata_nxt = {24'h000000, curHi, 2'h0, chanSel_r, convEn_r};
        `RFC_IDX_TRG:   rdata_nxt = {29'h0, trg_r};
        `RFC_IDX_MCL:   rdata_nxt = {16'h0000, mc_r[15:0]};
        `RFC_IDX_MCH:   rdata_nxt = {24'h000000, mc_r[23:16]};
        `RFC_IDX_TCL:   rdata_nxt = {16'h0000, tc_r[15:0]};
        `RFC_IDX_TCH:   rdata_nxt = {24'h000000, tc_r[23:16]};
        `RFC_IDX_IMSK:  rdata_nxt = {27'h0, mask_r};
        `RFC_IDX_IFLG:  rdata_nxt = {27'h0, flag_r};
        `RFC_IDX_CKCTL: rdata_nxt = {28'h0, ckCtl_r};
        default:        rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      done_r     <= 1'b0;
      rdata_r    <= 32'h00000000;
      convEn_r   <= 1'b0;
      chanSel_r  <= 1'b0;
      ctlHi_r[0] <= 4'h0;
      ctlHi_r[1] <= 4'h0;
      ckCtl_r    <= `RFC_CKCTL_RST;
      trg_r      <= 3'h0;
      mc_r       <= 24'h000000;
      tc_r       <= 24'h000000;
      mask_r     <= 5'h00;
      flag_r     <= 5'h00;
      pinPrev_r  <= 1'b0;
      state_r    <= rfc_pkg::ST_IDLE;
    end else if (ce) begin
      done_r     <= done_nxt;
      rdata_r    <= rdata_nxt;
      convEn_r   <= convEn_nxt;
      chanSel_r  <= chanSel_nxt;
      ctlHi_r    <= ctlHi_nxt;
      ckCtl_r    <= ckCtl_nxt;
      trg_r      <= trg_nxt;
      mc_r       <= mc_nxt;
      tc_r       <= tc_nxt;
      mask_r     <= mask_nxt;
      flag_r     <= flag_nxt;
      pinPrev_r  <= pinPrev_nxt;
      state_r    <= state_nxt;
    end
  end
endmodule : rfc_conv_ctrl
`default_nettype wire

// ==== verilog/rfc_tick_gen.sv ====
`timescale 1ns/1ns
`default_nettype none
module rfc_tick_gen (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       ce,
  // count clock setup
  input  wire logic       countClockGate,
  input  wire logic       countClockSourceSel,
  input  wire logic [1:0] fastClockDividerSel,
  input  wire logic       lowSpeedOscillator,
  // time base clock tick
  output logic            timeBaseTick
);
  logic [2:0] divCnt_r, divCnt_nxt;
  logic       slowPrev_r, slowPrev_nxt;
  logic [2:0] divMask;

  // -----------------------------------------------------------------
  // divider and slow edge detect
  // -----------------------------------------------------------------
  always_comb begin
    divMask      = 3'(({1'b0, 3'h0} + 4'((4'h1 << fastClockDividerSel) - 4'h1)));
    slowPrev_nxt = lowSpeedOscillator;
    divCnt_nxt   = countClockGate ? 3'(divCnt_r + 3'h1) : 3'h0;
    if (countClockSourceSel) begin
      timeBaseTick = countClockGate & lowSpeedOscillator & ~slowPrev_r;
    end else begin
      timeBaseTick = countClockGate & ((divCnt_r & divMask) == divMask);
    end
    if (!ce) begin
      timeBaseTick = 1'b0;
    end
  end

  // registers
  always_ff @(posedge clk) begin
    if (srst) begin
      divCnt_r   <= 3'h0;
      slowPrev_r <= 1'b0;
    end else if (ce) begin
      divCnt_r   <= divCnt_nxt;
      slowPrev_r <= slowPrev_nxt;
    end
  end
endmodule : rfc_tick_gen
`default_nettype wire
